// ===== src/twg_pkg.sv
package twg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] TWG_ADDR_CTRL2  = 8'h15;
    localparam logic [7:0] TWG_ADDR_STATUS = 8'h16;
    localparam logic [7:0] TWG_ADDR_INTST  = 8'h17;
    localparam logic [7:0] TWG_ADDR_INTMSK = 8'h18;
    localparam logic [7:0] TWG_ADDR_CTRL1  = 8'h19;
    localparam logic [7:0] TWG_ADDR_PERIOD = 8'h1A;

    localparam logic [7:0] TWG_RST_CTRL2   = 8'h00;
    localparam logic [7:0] TWG_RST_STATUS  = 8'h00;
    localparam logic [7:0] TWG_RST_CTRL1   = 8'h00;
    localparam logic [7:0] TWG_RST_PERIOD  = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TWG_BIT_EDGE    = 7;
    localparam int TWG_BIT_SRC_HI  = 6;
    localparam int TWG_BIT_SRC_LO  = 5;
    localparam int TWG_BIT_IEDGE   = 4;
    localparam int TWG_BIT_PCK_HI  = 3;
    localparam int TWG_BIT_PCK_LO  = 2;
    localparam int TWG_BIT_ROUTE   = 1;
    localparam int TWG_BIT_GATEFLG = 7;
    localparam int TWG_BIT_OVFFLG  = 6;
    localparam int TWG_BIT_START   = 0;
    localparam int TWG_BIT_CLEAR   = 1;
    localparam int TWG_BIT_DVMODE  = 2;
    localparam int TWG_BIT_EVT     = 0;

    // ------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------
    localparam int          TWG_CNT_W     = 18;
    localparam int          TWG_PRE_W     = 14;
    localparam logic [4:0]  TWG_UNITS_MAX = 5'h10;
    localparam logic [3:0]  TWG_SHIFT_F0  = 4'hC;
    localparam logic [3:0]  TWG_SHIFT_S0  = 4'h4;

    typedef enum logic [1:0] {
        TWG_SRC_PIN,
        TWG_SRC_INTERNAL,
        TWG_SRC_TIMER6,
        TWG_SRC_RESERVED
    } twg_src_t;

    // Control fields decoded from the second control register
    typedef struct packed {
        logic       countEdgeSelect;
        twg_src_t   gateSourceSelect;
        logic       gateInterruptEdge;
        logic [1:0] gatePeriodClockSelect;
        logic       timer6PinRoute;
    } twg_ctrl_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } twg_bus_t;

endpackage

// ===== src/twg_edge_det.sv
`timescale 1ns/1ns
`default_nettype none

// Edge detector on a synchronous level
module twg_edge_det (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic enable,
    input  wire logic level,
    input  wire logic bothEdges,
    output logic      fall,
    output logic      hit
);
    logic last;
    logic next_last;

    // Previous sample
    always_comb begin
        next_last = enable ? level : last;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last <= 1'b0;
        end else begin
            last <= next_last;
        end
    end

    assign fall = enable & last & ~level;
    assign hit  = enable & (last ^ level) & (bothEdges | last);
endmodule

`default_nettype wire

// ===== src/twg_gate_gen.sv
`timescale 1ns/1ns
`default_nettype none

// Internal window gate: high (16-Ta) units, low (16-Tb) units
module twg_gate_gen (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       enable,
    input  wire logic       run,
    input  wire logic       unitTick,
    input  wire logic [3:0] highSet,
    input  wire logic [3:0] lowSet,
    output logic            gate
);
    import twg_pkg::*;

    logic [4:0] units;
    logic [4:0] next_units;
    logic       next_gate;
    logic [4:0] target;

    // Count time units, flip phase at 16 minus setting
    always_comb begin
        target     = gate ? (TWG_UNITS_MAX - {1'b0, highSet}) : (TWG_UNITS_MAX - {1'b0, lowSet});
        next_units = units;
        next_gate  = gate;
        if (!enable) begin
            next_units = units;
        end else if (!run) begin
            next_units = 5'h00;
            next_gate  = 1'b1;
        end else if (unitTick) begin
            if (units + 5'h01 >= target) begin // RULE6
                next_units = 5'h00;
                next_gate  = ~gate;
            end else begin
                next_units = units + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            units <= 5'h00;
            gate  <= 1'b1;
        end else begin
            units <= next_units;
            gate  <= next_gate;
        end
    end
endmodule

`default_nettype wire

// ===== src/twg_timer1_gate.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Timer 1 window gate and count configuration
// ------------------------------------------------------------
// Summary of operation
// [RULE1] Edge bit 0 counts falling input edges; 1 counts both edges.
// [RULE2] Gate source 01 internal generator, 10 inverted timer six, 11 reserved.
// [RULE3] Gate source 00 uses the external input pin as gate.
// [RULE4] Interrupt edge bit 0: gate falling edge; 1: both gate edges.
// [RULE5] Period clock 00/01/10 gives 2^12..14 fast or 2^4..6 slow periods.
// [RULE6] Internal gate high 16-Ta units, low 16-Tb units.
// [RULE7] Route bit 0 drives timer six output to pin 33; 1 does not.
// [RULE8] Software changes selections only while the timer is stopped.
// [RULE9] Software writes zero to bit 0 of control register two.
// [RULE10] Software keeps edge bit 0 in event and pulse width modes.
// [RULE11] Status bit 7 reads 1 while gate high counting, else 0.
// [RULE12] Counter wrap sets overflow flag, held until counter clear.
// [RULE13] Status register is read only; low six bits read zero.
module twg_timer1_gate (
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire logic            clkEnable,
    input  wire twg_pkg::twg_bus_t bus,
    output logic [7:0]           rdata,
    input  wire logic            externalCountInput,
    input  wire logic            timerSixOutput,
    output logic                 portPinThreeThree,
    output logic                 portPinThreeThreeOe,
    output logic                 timerInterrupt,
    output logic                 irq
);
    import twg_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]             ctrl2, next_ctrl2;
    logic [7:0]             ctrl1, next_ctrl1;
    logic [7:0]             period, next_period;
    logic [7:0]             intSt, next_intSt;
    logic [7:0]             intMsk, next_intMsk;
    logic [7:0]             next_rdata;
    logic [TWG_CNT_W-1:0]   counter, next_counter;
    logic                   ovfFlag, next_ovfFlag;
    logic [TWG_PRE_W-1:0]   pre, next_pre;
    logic                   next_pin, next_pinOe, next_tint, next_irq;
    twg_ctrl_t              ctrl;
    logic                   running, gateInt, gateSel;
    logic                   cntHit, gateHit, unitTick;
    logic [3:0]             shiftSel;
    logic [TWG_PRE_W-1:0]   preMask;

    assign ctrl    = twg_ctrl_t'(ctrl2[7:1]);
    assign running = ctrl1[TWG_BIT_START];

    // ------------------------------------------------------------
    // Gate period prescaler
    // ------------------------------------------------------------
    // Fast clock with divider bit 0 uses 2^12.., otherwise 2^4..  [RULE5]
    always_comb begin
        shiftSel = (ctrl1[TWG_BIT_DVMODE] ? TWG_SHIFT_S0 : TWG_SHIFT_F0)
                 + {2'b00, ctrl.gatePeriodClockSelect};                   // RULE5
        preMask  = TWG_PRE_W'((15'h0001 << shiftSel) - 15'h0001);
        unitTick = running && ((pre & preMask) == preMask)
                 && (ctrl.gatePeriodClockSelect != 2'b11);                // RULE5
        next_pre = !running ? '0 : pre + TWG_PRE_W'(1);
    end

    twg_gate_gen u_gate (
        .clk      (clk),
        .reset_n  (reset_n),
        .enable   (clkEnable),
        .run      (running),
        .unitTick (unitTick),
        .highSet  (period[7:4]),                              // RULE6
        .lowSet   (period[3:0]),
        .gate     (gateInt)
    );

    // Gate source multiplexer; reserved code holds gate low  [RULE2] [RULE3]
    always_comb begin
        case (ctrl.gateSourceSelect)
            TWG_SRC_PIN:      gateSel = externalCountInput;   // RULE3
            TWG_SRC_INTERNAL: gateSel = gateInt;              // RULE2
            TWG_SRC_TIMER6:   gateSel = ~timerSixOutput;      // RULE2
            default:          gateSel = 1'b0;                 // RULE2
        endcase
    end

    twg_edge_det u_cntEdge (
        .clk       (clk),
        .reset_n   (reset_n),
        .enable    (clkEnable),
        .level     (externalCountInput),
        .bothEdges (ctrl.countEdgeSelect),                    // RULE1
        .fall      (),
        .hit       (cntHit)
    );

    twg_edge_det u_gateEdge (
        .clk       (clk),
        .reset_n   (reset_n),
        .enable    (clkEnable),
        .level     (gateSel),
        .bothEdges (ctrl.gateInterruptEdge),                  // RULE4
        .fall      (),
        .hit       (gateHit)
    );

    // ------------------------------------------------------------
    // Counter and overflow
    // ------------------------------------------------------------
    // Counts selected input edges while the gate is high; a clear
    // request wipes the count, and the overflow unless the count wraps that cycle; a stop wipes both.  [RULE12]
    always_comb begin
        next_counter = counter;
        next_ovfFlag = ovfFlag;
        if (!running || ctrl1[TWG_BIT_CLEAR]) begin
            next_counter = '0;
            next_ovfFlag = 1'b0;                                           // RULE12
        end else if (cntHit && gateSel) begin                              // RULE1
            next_counter = counter + TWG_CNT_W'(1);
        end
        // A wrap in the cycle of a clear still leaves the flag set
        if (running && cntHit && gateSel && (&counter)) begin
            next_ovfFlag = 1'b1;                                           // RULE12
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Writes; status address ignores writes, clear bit self-clears  [RULE13]
    always_comb begin
        next_ctrl2  = ctrl2;
        next_ctrl1  = ctrl1;
        next_period = period;
        next_intMsk = intMsk;
        next_ctrl1[TWG_BIT_CLEAR] = 1'b0;
        if (bus.wr) begin
            case (bus.addr)
                TWG_ADDR_CTRL2:  next_ctrl2  = {bus.wdata[7:1], 1'b0};
                TWG_ADDR_CTRL1:  next_ctrl1  = bus.wdata & 8'h07;
                TWG_ADDR_PERIOD: next_period = bus.wdata;
                TWG_ADDR_INTMSK: next_intMsk = bus.wdata & 8'h01;
                default:         next_ctrl2  = ctrl2;
            endcase
        end
    end

    // Read mux; bits 5..0 of status always zero  [RULE11] [RULE13]
    always_comb begin
        case (bus.addr)
            TWG_ADDR_CTRL2:  next_rdata = ctrl2;
            TWG_ADDR_STATUS: next_rdata = {gateSel & running, ovfFlag, 6'h00}; // RULE11
            TWG_ADDR_INTST:  next_rdata = intSt;
            TWG_ADDR_INTMSK: next_rdata = intMsk;
            TWG_ADDR_CTRL1:  next_rdata = ctrl1;
            TWG_ADDR_PERIOD: next_rdata = period;
            default:         next_rdata = 8'h00;
        endcase
        if (!bus.rd) begin
            next_rdata = 8'h00;
        end
    end

    // Sticky gate-edge event; set wins over read clear  [RULE4]
    always_comb begin
        next_intSt = intSt;
        if (bus.rd && bus.addr == TWG_ADDR_INTST) begin
            next_intSt = 8'h00;
        end
        if (gateHit && running) begin
            next_intSt[TWG_BIT_EVT] = 1'b1;                                // RULE4
        end
        next_tint  = gateHit && running;                                   // RULE4
        next_irq   = |(next_intSt & intMsk);
        next_pin   = timerSixOutput;
        next_pinOe = ~ctrl.timer6PinRoute;                                 // RULE7
    end

    // Registered state, frozen while the clock enable is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl2               <= TWG_RST_CTRL2;
            ctrl1               <= TWG_RST_CTRL1;
            period              <= TWG_RST_PERIOD;
            intSt               <= 8'h00;
            intMsk              <= 8'h00;
            rdata               <= 8'h00;
            counter             <= '0;
            ovfFlag             <= 1'b0;
            pre                 <= '0;
            portPinThreeThree   <= 1'b0;
            portPinThreeThreeOe <= 1'b0;
            timerInterrupt      <= 1'b0;
            irq                 <= 1'b0;
        end else if (clkEnable) begin
            ctrl2               <= next_ctrl2;
            ctrl1               <= next_ctrl1;
            period              <= next_period;
            intSt               <= next_intSt;
            intMsk              <= next_intMsk;
            rdata               <= next_rdata;
            counter             <= next_counter;
            ovfFlag             <= next_ovfFlag;
            pre                 <= next_pre;
            portPinThreeThree   <= next_pin;
            portPinThreeThreeOe <= next_pinOe;
            timerInterrupt      <= next_tint;
            irq                 <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_wrap;
        clkEnable && running && cntHit && gateSel && (&counter);
    endsequence

    a_overflow_set: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        s_wrap |=> ovfFlag) else $error("overflow flag not set on wrap");

    a_overflow_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        (clkEnable && ovfFlag && running && !ctrl1[TWG_BIT_CLEAR]) |=> ovfFlag)
        else $error("overflow flag dropped without clear");

    a_status_low_zero: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
        (clkEnable && bus.rd && bus.addr == TWG_ADDR_STATUS) |=> rdata[5:0] == 6'h00)
        else $error("status low bits not zero");

    a_status_gate_bit: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
        (clkEnable && bus.rd && bus.addr == TWG_ADDR_STATUS)
        |=> rdata[7] == $past(gateSel & running))
        else $error("gate flag mismatch");

    a_route_enable: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
        clkEnable |=> portPinThreeThreeOe == !$past(ctrl2[TWG_BIT_ROUTE]))
        else $error("pin route enable wrong");

    a_count_fall_only: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
        (clkEnable && running && !ctrl.countEdgeSelect && $rose(externalCountInput)
         && !ctrl1[TWG_BIT_CLEAR]) |=> counter == $past(counter))
        else $error("counted a rising edge");

    a_irq_fall_only: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
        (clkEnable && !ctrl.gateInterruptEdge && gateHit)
        |-> !gateSel)
        else $error("interrupt on rising gate edge");

    a_timer6_gate: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
        (ctrl.gateSourceSelect == TWG_SRC_TIMER6) |-> gateSel == !timerSixOutput)
        else $error("timer six gate not inverted");

    a_pin_gate: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
        (ctrl.gateSourceSelect == TWG_SRC_PIN) |-> gateSel == externalCountInput)
        else $error("pin gate not selected");

    // Gate edges reach the interrupt pulse one cycle later
    sequence s_gate_fell;
        clkEnable && $past(clkEnable) && running && $fell(gateSel);
    endsequence

    sequence s_gate_rose;
        clkEnable && $past(clkEnable) && running && $rose(gateSel);
    endsequence

    a_gate_fall_irq: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
        s_gate_fell |=> timerInterrupt)
        else $error("no interrupt on gate fall");

    a_gate_rise_irq: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
        (s_gate_rose ##0 ctrl.gateInterruptEdge) |=> timerInterrupt)
        else $error("no interrupt on gate rise");

    // Input edges inside the gate advance the counter by one
    sequence s_pin_fell;
        clkEnable && $past(clkEnable) && running && !ctrl1[TWG_BIT_CLEAR] && gateSel
            && $fell(externalCountInput);
    endsequence

    sequence s_pin_rose;
        clkEnable && $past(clkEnable) && running && !ctrl1[TWG_BIT_CLEAR] && gateSel
            && $rose(externalCountInput);
    endsequence

    a_count_falls: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
        s_pin_fell |=> counter == $past(counter) + TWG_CNT_W'(1))
        else $error("falling input edge not counted");

    a_count_rises: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
        (s_pin_rose ##0 ctrl.countEdgeSelect) |=> counter == $past(counter) + TWG_CNT_W'(1))
        else $error("rising input edge not counted");

    a_reserved_gate: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
        (ctrl.gateSourceSelect == TWG_SRC_RESERVED) |-> !gateSel)
        else $error("reserved gate source not held low");

    a_pin_copy: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
        clkEnable |=> portPinThreeThree == $past(timerSixOutput))
        else $error("pin 33 does not follow timer six");

    a_stop_clears: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        (clkEnable && !running) |=> (!ovfFlag && counter == '0))
        else $error("stop left count or overflow");
endmodule

`default_nettype wire

// ===== testbench/twg_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Far side: count/gate input pin and timer six output
// ------------------------------------------------------------
module twg_pin_model (
    input  wire logic clk,
    input  wire logic wantPin,
    input  wire logic wantSix,
    output logic      externalCountInput = 1'b0,
    output logic      timerSixOutput     = 1'b0
);
    // Both levels move just after a rising edge, like a synchronous source
    always @(posedge clk) begin
        externalCountInput <= wantPin;
        timerSixOutput     <= wantSix;
    end
endmodule

`default_nettype wire

// ===== testbench/twg_timer1_gate_test.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin badCount++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module twg_timer1_gate_test;
    import twg_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk = 1'b0;
    logic       resetN;
    logic       clkEnable;
    twg_bus_t   bus;
    logic [7:0] rdata;
    logic       wantPin;
    logic       wantSix;
    logic       externalCountInput;
    logic       timerSixOutput;
    logic       portPinThreeThree;
    logic       portPinThreeThreeOe;
    logic       timerInterrupt;
    logic       irq;
    int         badCount = 0;
    int         nCompared = 0;
    int         cycle = 0;
    int         q[$];
    logic [7:0] d;
    logic [7:0] junk;
    logic [3:0] ta;
    logic [3:0] tb;
    logic [1:0] code;
    logic       dv;

    always #50 clk = ~clk;

    twg_timer1_gate dut (
        .clk                 (clk),
        .reset_n             (resetN),
        .clkEnable           (clkEnable),
        .bus                 (bus),
        .rdata               (rdata),
        .externalCountInput  (externalCountInput),
        .timerSixOutput      (timerSixOutput),
        .portPinThreeThree   (portPinThreeThree),
        .portPinThreeThreeOe (portPinThreeThreeOe),
        .timerInterrupt      (timerInterrupt),
        .irq                 (irq)
    );

    twg_pin_model partner (
        .clk                (clk),
        .wantPin            (wantPin),
        .wantSix            (wantSix),
        .externalCountInput (externalCountInput),
        .timerSixOutput     (timerSixOutput)
    );

    // Cycle count, hang guard and interrupt pulse log
    always @(posedge clk) begin
        cycle <= cycle + 1;
        if (timerInterrupt === 1'b1) begin
            q.push_back(cycle);
        end
        if (cycle == 80000) begin
            badCount++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks and expectations
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b0, rd: 1'b0};
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdReg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        #1;
        v = rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] ex, input string nm);
        logic [7:0] v;
        rdReg(a, v);
        `CHK(nm, ex, v)
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Gate time unit in clocks: fast clock when divider bit is 0
    function automatic int unitLen(input logic slow, input logic [1:0] c);
        return slow ? (16 << c) : (4096 << c);
    endfunction

    task automatic results();
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        bus = '0;
        wantPin = 1'b0;
        wantSix = 1'b0;
        clkEnable = 1'b1;
        resetN = 1'b0;
        void'($urandom(32'h495C91F5));
        repeat (5) @(posedge clk);
        resetN <= 1'b1;
        cycles(2);
        #1;
        `CHK("route enable", 1'b1, portPinThreeThreeOe)
        rdchk(TWG_ADDR_CTRL2, TWG_RST_CTRL2, "ctrl2 reset");
        rdchk(TWG_ADDR_STATUS, TWG_RST_STATUS, "status reset");
        // Refused accesses: bit 0 stuck, status read only, hole reads zero
        wr(TWG_ADDR_CTRL2, 8'hFF);
        rdchk(TWG_ADDR_CTRL2, 8'hFE, "ctrl2 bit0");
        wr(TWG_ADDR_STATUS, 8'hFF);
        rdchk(TWG_ADDR_STATUS, 8'h00, "status write");
        rdchk(8'h3C, 8'h00, "unmapped");
        // Random settings while stopped, route bit steering pin 33
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom) & 8'hFE;
            wantSix <= 1'($urandom);
            wr(TWG_ADDR_CTRL2, d);
            cycles(3);
            `CHK("route enable", ~d[1], portPinThreeThreeOe)
            if (!d[1]) `CHK("pin 33", timerSixOutput, portPinThreeThree)
            rdchk(TWG_ADDR_CTRL2, d, "ctrl2 value");
        end
        // Low clock enable freezes the registers, so this write is lost
        @(posedge clk);
        clkEnable <= 1'b0;
        wr(TWG_ADDR_CTRL2, ~d & 8'hFE);
        clkEnable <= 1'b1;
        rdchk(TWG_ADDR_CTRL2, d, "ctrl2 frozen");
        // Gate from pin, then inverted timer six, then reserved code
        for (int s = 0; s < 3; s++) begin
            wr(TWG_ADDR_CTRL1, 8'h00);
            wr(TWG_ADDR_CTRL2, (s == 0) ? 8'h00 : ((s == 1) ? 8'h40 : 8'h60));
            wr(TWG_ADDR_CTRL1, 8'h01);
            for (int lv = 0; lv < 2; lv++) begin
                wantPin <= 1'(lv);
                wantSix <= 1'(lv);
                cycles(4);
                d = (s == 0) ? 8'(lv << 7) : ((s == 1) ? 8'((1 - lv) << 7) : 8'h00);
                rdchk(TWG_ADDR_STATUS, d, "gate flag");
            end
        end
        // Interrupt edge choice, sticky status, mask and level output
        for (int e = 0; e < 2; e++) begin
            wr(TWG_ADDR_CTRL1, 8'h00);
            wantPin <= 1'b0;
            wr(TWG_ADDR_CTRL2, 8'(e << 4));
            wr(TWG_ADDR_INTMSK, 8'(e));
            wr(TWG_ADDR_CTRL1, 8'h01);
            cycles(3);
            rdReg(TWG_ADDR_INTST, junk);
            q.delete();
            wantPin <= 1'b1;
            cycles(6);
            wantPin <= 1'b0;
            cycles(6);
            `CHK("gate edge pulses", e + 1, q.size())
            `CHK("irq level", 1'(e), irq)
            rdchk(TWG_ADDR_INTST, 8'h01, "event status");
            rdchk(TWG_ADDR_INTST, 8'h00, "event cleared");
            cycles(2);
            `CHK("irq cleared", 1'b0, irq)
        end
        // Internal gate period over slow codes and one fast code
        for (int k = 0; k < 4; k++) begin
            dv = (k != 3);
            code = (k == 3) ? 2'h0 : 2'(k);
            ta = (k == 3) ? 4'hF : 4'hC + 4'($urandom % 4);
            tb = (k == 3) ? 4'hF : 4'hC + 4'($urandom % 4);
            wr(TWG_ADDR_CTRL1, 8'h00);
            wr(TWG_ADDR_PERIOD, {ta, tb});
            wr(TWG_ADDR_CTRL2, 8'h20 | 8'(code << 2));
            wr(TWG_ADDR_CTRL1, {5'h00, dv, 2'b01});
            q.delete();
            for (int w = 0; w < 40000 && q.size() < 3; w++) @(posedge clk);
            `CHK("gate period", (32 - ta - tb) * unitLen(dv, code), q[2] - q[1])
        end
        // Mid-run reset brings the registers back to their reset values
        @(posedge clk);
        resetN <= 1'b0;
        cycles(2);
        resetN <= 1'b1;
        cycles(2);
        #1;
        `CHK("route after reset", 1'b1, portPinThreeThreeOe)
        rdchk(TWG_ADDR_STATUS, TWG_RST_STATUS, "status after reset");
        rdchk(TWG_ADDR_CTRL2, TWG_RST_CTRL2, "ctrl2 after reset");
        results();
    end
endmodule

`default_nettype wire
